// File: rtl/elfn_pkg.sv
// Package for the error-log register group: offsets, field layouts and reset values.
// Assumes configuration accesses by dword address with byte enables.
package elfn_pkg;
  localparam int ELFN_ADDR_W = 8;
  // Register offsets (byte addresses in configuration space)
  localparam logic [7:0] ELFN_OFS_GLOBAL_NEXT = 8'h44;
  localparam logic [7:0] ELFN_OFS_HUB_A_FIRST = 8'h50;
  localparam logic [7:0] ELFN_OFS_HUB_A_NEXT = 8'h52;
  localparam logic [7:0] ELFN_OFS_CTRL_IRQ_EN = 8'h58;
  localparam logic [7:0] ELFN_OFS_MGMT_IRQ_EN = 8'h5A;
  // Global flag positions
  localparam int ELFN_GBIT_DRAM = 18;
  localparam int ELFN_GBIT_HUB_A = 17;
  localparam int ELFN_GBIT_SYSBUS = 16;
  localparam int ELFN_GBIT_HUB_D = 4;
  localparam int ELFN_GBIT_HUB_C = 3;
  localparam int ELFN_GBIT_HUB_B = 2;
  localparam logic [31:0] ELFN_GLOBAL_MASK = 32'h0007001C;
  localparam logic [31:0] ELFN_DEV0_GROUP = 32'h00070000;
  // Hub link A flag positions
  localparam int ELFN_ABIT_TABORT = 6;
  localparam int ELFN_ABIT_DPAR = 4;
  localparam int ELFN_ABIT_APAR = 0;
  localparam logic [7:0] ELFN_HUB_A_MASK = 8'h51;
  // Reset values
  localparam logic [31:0] ELFN_GLOBAL_NEXT_RST = 32'h00000000;
  localparam logic [7:0] ELFN_HUB_A_RST = 8'h00;
  localparam logic [7:0] ELFN_IRQ_EN_RST = 8'h00;
endpackage

// File: rtl/elfn_error_log.sv
// Error-log register group: global next-error flags, hub link A first/next flags,
// control and management interrupt enables, and their interrupt requests.
// Assumes error events are single-cycle pulses from logic on clk_sys_in, and the
// global first-error register lives elsewhere and is presented on global_first_error_in.
`timescale 1ns/100ps
`default_nettype none
module elfn_error_log
  import elfn_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic pwr_rst_in,
  input wire logic cfg_wr_en_in,
  input wire logic cfg_rd_en_in,
  input wire logic [ELFN_ADDR_W-1:0] cfg_addr_in,
  input wire logic [3:0] cfg_be_in,
  input wire logic [31:0] cfg_wdata_in,
  output logic [31:0] cfg_rdata_out,
  output logic cfg_rd_valid_out,
  input wire logic [31:0] global_first_error_in,
  input wire logic dram_err_in,
  input wire logic sysbus_err_in,
  input wire logic hub_link_b_err_in,
  input wire logic hub_link_c_err_in,
  input wire logic hub_link_d_err_in,
  input wire logic hub_a_target_abort_in,
  input wire logic hub_a_data_par_in,
  input wire logic hub_a_addr_par_in,
  input wire logic system_error_enable_in,
  output logic control_interrupt_out,
  output logic management_interrupt_out,
  output logic system_error_out
);

  logic [31:0] global_next_q;
  logic [31:0] global_next_d;
  logic [7:0] hub_a_first_q;
  logic [7:0] hub_a_first_d;
  logic [7:0] hub_a_next_q;
  logic [7:0] hub_a_next_d;
  logic [7:0] ctrl_en_q;
  logic [7:0] mgmt_en_q;
  logic [31:0] rdata_q;
  logic rd_valid_q;
  logic ctrl_irq_q;
  logic mgmt_irq_q;
  logic serr_q;

  logic [5:0] dw_addr;
  logic wr_dw_44;
  logic wr_dw_50;
  logic wr_dw_58;
  logic hit_44;
  logic hit_50;
  logic hit_58;
  logic [31:0] global_clr;
  logic [7:0] first_clr;
  logic [7:0] next_clr;
  logic [7:0] hub_a_evt;
  logic [7:0] hub_a_pick;
  logic [31:0] global_evt;
  logic [31:0] global_block;
  logic [31:0] global_set;
  logic [7:0] first_left;
  logic first_free;
  logic first_held;
  logic [31:0] lane_mask;
  logic [31:0] wr_ones;
  logic [31:0] global_rise;
  logic [7:0] hub_a_flags;
  logic [31:0] rd_mux;

  // Two low address bits are ignored; every register sits in a whole dword, and
  // a narrower register is picked out by its byte lane
  assign dw_addr = cfg_addr_in[7:2];
  assign hit_44 = (dw_addr == ELFN_OFS_GLOBAL_NEXT[7:2]);
  assign hit_50 = (dw_addr == ELFN_OFS_HUB_A_FIRST[7:2]);
  assign hit_58 = (dw_addr == ELFN_OFS_CTRL_IRQ_EN[7:2]);
  assign wr_dw_44 = cfg_wr_en_in && hit_44;
  assign wr_dw_50 = cfg_wr_en_in && hit_50;
  assign wr_dw_58 = cfg_wr_en_in && hit_58;

  // Only ones in enabled byte lanes clear; a disabled lane or a zero bit leaves the flag alone
  assign lane_mask = {{8{cfg_be_in[3]}}, {8{cfg_be_in[2]}}, {8{cfg_be_in[1]}}, {8{cfg_be_in[0]}}};
  assign wr_ones = cfg_wdata_in & lane_mask;
  assign global_clr = wr_dw_44 ? wr_ones : 32'h00000000;
  assign first_clr = wr_dw_50 ? wr_ones[7:0] : 8'h00;
  assign next_clr = wr_dw_50 ? wr_ones[23:16] : 8'h00;

  always_comb begin
    hub_a_evt = 8'h00;
    hub_a_evt[ELFN_ABIT_TABORT] = hub_a_target_abort_in;
    hub_a_evt[ELFN_ABIT_DPAR] = hub_a_data_par_in;
    hub_a_evt[ELFN_ABIT_APAR] = hub_a_addr_par_in;
  end

  // Fixed priority when several errors arrive together: address/command, then data,
  // then abort; the losers are not dropped but land in the next-error register
  always_comb begin
    hub_a_pick = 8'h00;
    if (hub_a_evt[ELFN_ABIT_APAR]) begin
      hub_a_pick[ELFN_ABIT_APAR] = 1'b1;
    end else if (hub_a_evt[ELFN_ABIT_DPAR]) begin
      hub_a_pick[ELFN_ABIT_DPAR] = 1'b1;
    end else if (hub_a_evt[ELFN_ABIT_TABORT]) begin
      hub_a_pick[ELFN_ABIT_TABORT] = 1'b1;
    end
  end

  // A slot cleared by a write in this cycle counts as free, so a new error takes it
  assign first_left = hub_a_first_q & ~first_clr;
  assign first_free = (first_left == 8'h00);

  always_comb begin
    if (first_free) begin
      hub_a_first_d = hub_a_pick;
    end else begin
      hub_a_first_d = first_left;
    end
  end

  // Set wins over a clear of the same bit in the same cycle
  always_comb begin
    if (first_free) begin
      hub_a_next_d = (hub_a_next_q & ~next_clr) | (hub_a_evt & ~hub_a_pick);
    end else begin
      hub_a_next_d = (hub_a_next_q & ~next_clr) | hub_a_evt;
    end
  end

  always_comb begin
    global_evt = 32'h00000000;
    global_evt[ELFN_GBIT_DRAM] = dram_err_in;
    global_evt[ELFN_GBIT_HUB_A] = |hub_a_evt;
    global_evt[ELFN_GBIT_SYSBUS] = sysbus_err_in;
    global_evt[ELFN_GBIT_HUB_D] = hub_link_d_err_in;
    global_evt[ELFN_GBIT_HUB_C] = hub_link_c_err_in;
    global_evt[ELFN_GBIT_HUB_B] = hub_link_b_err_in;
  end

  // First-error register counts as held when any of its valid flags is set
  assign first_held = ((global_first_error_in & ELFN_GLOBAL_MASK) != 32'h00000000);

  // A device-internal first error (bits 18..16) blocks the whole group, but other
  // links still log so their later faults are not lost
  always_comb begin
    global_block = global_first_error_in & ELFN_GLOBAL_MASK;
    if ((global_first_error_in & ELFN_DEV0_GROUP) != 32'h00000000) begin
      global_block = global_block | ELFN_DEV0_GROUP;
    end
  end

  // Only errors after the first one is held are next errors
  assign global_set = first_held ? (global_evt & ~global_block) : 32'h00000000;

  // Set wins over a clear in the same cycle
  assign global_next_d = ((global_next_q & ~global_clr) | global_set) & ELFN_GLOBAL_MASK;
  assign global_rise = global_next_d & ~global_next_q;

  // Sticky flags: only power-up reset clears them, so an ordinary reset leaves
  // the error history readable for the handler that runs after it
  always_ff @(posedge clk_sys_in or posedge pwr_rst_in) begin
    if (pwr_rst_in) begin
      global_next_q <= ELFN_GLOBAL_NEXT_RST;
    end else begin
      global_next_q <= global_next_d;
    end
  end

  always_ff @(posedge clk_sys_in or posedge pwr_rst_in) begin
    if (pwr_rst_in) begin
      hub_a_first_q <= ELFN_HUB_A_RST;
    end else begin
      hub_a_first_q <= hub_a_first_d & ELFN_HUB_A_MASK;
    end
  end

  always_ff @(posedge clk_sys_in or posedge pwr_rst_in) begin
    if (pwr_rst_in) begin
      hub_a_next_q <= ELFN_HUB_A_RST;
    end else begin
      hub_a_next_q <= hub_a_next_d & ELFN_HUB_A_MASK;
    end
  end

  // Enables are not sticky: an ordinary reset disarms the control and management requests
  // until software programs them again
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ctrl_en_q <= ELFN_IRQ_EN_RST;
    end else if (wr_dw_58 && cfg_be_in[0]) begin
      ctrl_en_q <= cfg_wdata_in[7:0] & ELFN_HUB_A_MASK;
    end
  end

  // Same bit layout as the control enables, in the upper half of the dword
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      mgmt_en_q <= ELFN_IRQ_EN_RST;
    end else if (wr_dw_58 && cfg_be_in[2]) begin
      mgmt_en_q <= cfg_wdata_in[23:16] & ELFN_HUB_A_MASK;
    end
  end

  // Unmapped dwords read zero
  always_comb begin
    rd_mux = 32'h00000000;
    case (dw_addr)
      ELFN_OFS_GLOBAL_NEXT[7:2]: begin
        rd_mux = global_next_q;
      end
      ELFN_OFS_HUB_A_FIRST[7:2]: begin
        rd_mux = {8'h00, hub_a_next_q, 8'h00, hub_a_first_q};
      end
      ELFN_OFS_CTRL_IRQ_EN[7:2]: begin
        rd_mux = {8'h00, mgmt_en_q, 8'h00, ctrl_en_q};
      end
      default: begin
        rd_mux = 32'h00000000;
      end
    endcase
  end

  // Read data holds until the next read, so a slow consumer may sample it late
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rdata_q <= 32'h00000000;
    end else if (cfg_rd_en_in) begin
      rdata_q <= rd_mux;
    end
  end

  // One-cycle strobe: a read is answered exactly one edge after it is taken
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= cfg_rd_en_in;
    end
  end

  // Requests follow registered flags, so they rise the cycle after a flag sets.
  // Software is trusted to enable only one message type per flag; nothing here arbitrates.
  assign hub_a_flags = hub_a_first_q | hub_a_next_q;

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ctrl_irq_q <= 1'b0;
    end else begin
      ctrl_irq_q <= |(hub_a_flags & ctrl_en_q);
    end
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      mgmt_irq_q <= 1'b0;
    end else begin
      mgmt_irq_q <= |(hub_a_flags & mgmt_en_q);
    end
  end

  // One pulse per cycle with a rising flag; a flag that is already set raises
  // nothing more until software clears it
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      serr_q <= 1'b0;
    end else begin
      serr_q <= system_error_enable_in && (global_rise != 32'h00000000);
    end
  end

  assign cfg_rdata_out = rdata_q;
  assign cfg_rd_valid_out = rd_valid_q;
  assign control_interrupt_out = ctrl_irq_q;
  assign management_interrupt_out = mgmt_irq_q;
  assign system_error_out = serr_q;

endmodule
`default_nettype wire

// File: sim/elfn_error_log_properties.sv
// Port-level properties of the error-log register group.
// Assumes binding to elfn_error_log; sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module elfn_error_log_properties
  import elfn_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic pwr_rst_in,
  input wire logic cfg_rd_en_in,
  input wire logic [ELFN_ADDR_W-1:0] cfg_addr_in,
  input wire logic [31:0] cfg_rdata_out,
  input wire logic cfg_rd_valid_out,
  input wire logic system_error_enable_in,
  input wire logic system_error_out,
  input wire logic control_interrupt_out,
  input wire logic management_interrupt_out
);
  // Dword of the read in flight, so rdata can be judged against its address
  logic [5:0] dw_q;
  always_ff @(posedge clk_sys_in) dw_q <= cfg_addr_in[7:2];
  wire rd_g = cfg_rd_valid_out && dw_q == 6'h11;
  wire rd_a = cfg_rd_valid_out && dw_q == 6'h14;
  wire rd_e = cfg_rd_valid_out && dw_q == 6'h16;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in || pwr_rst_in);
  a_rd_valid_next: assert property (cfg_rd_en_in |=> cfg_rd_valid_out) else $error("no read valid");
  a_rd_valid_cause: assert property (cfg_rd_valid_out |-> $past(cfg_rd_en_in)) else $error("stray valid");
  a_global_rsvd_zero: assert property (rd_g |-> (cfg_rdata_out & ~ELFN_GLOBAL_MASK) == 32'h0)
    else $error("global reserved bits set");
  a_first_single_flag: assert property (rd_a |-> $onehot0(cfg_rdata_out[7:0])) else $error("two first flags");
  a_hub_rsvd_zero: assert property (rd_a |-> (cfg_rdata_out & 32'hFFAEFFAE) == 32'h0)
    else $error("hub reserved bits set");
  a_enable_rsvd_zero: assert property (rd_e |-> (cfg_rdata_out & 32'hFFAEFFAE) == 32'h0)
    else $error("enable reserved bits set");
  a_unmapped_zero: assert property (cfg_rd_valid_out && !(rd_g || rd_a || rd_e) |-> cfg_rdata_out == 32'h0)
    else $error("unmapped read not zero");
  a_serr_when_enabled: assert property (system_error_out |-> $past(system_error_enable_in))
    else $error("system error while disabled");
  c_ctrl_irq: cover property (control_interrupt_out);
  c_mgmt_irq: cover property (management_interrupt_out);
  c_serr: cover property (system_error_out);
endmodule
bind elfn_error_log elfn_error_log_properties elfn_error_log_properties_i (.clk_sys_in(clk_sys_in),
  .sys_rst_in(sys_rst_in), .pwr_rst_in(pwr_rst_in), .cfg_rd_en_in(cfg_rd_en_in), .cfg_addr_in(cfg_addr_in),
  .cfg_rdata_out(cfg_rdata_out), .cfg_rd_valid_out(cfg_rd_valid_out),
  .system_error_enable_in(system_error_enable_in), .system_error_out(system_error_out),
  .control_interrupt_out(control_interrupt_out), .management_interrupt_out(management_interrupt_out));
`default_nettype wire

// File: sim/elfn_error_log_tb.sv
// Directed testbench for the error-log register group.
// Assumes the package, design and checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
module elfn_error_log_tb;
  logic clk = 1'b0, srst = 1'b1, prst = 1'b1, wr = 1'b0, rd = 1'b0, sen = 1'b1, rdv, cirq, mirq, serr, seen;
  logic [7:0] addr = 8'h00, ev = 8'h00;
  logic [3:0] be = 4'h0;
  logic [31:0] wd = 32'h0, gfirst = 32'h0, rdat;
  int error_cnt = 0, cmp_count = 0;
  elfn_error_log elfn_error_log_i (.clk_sys_in(clk), .sys_rst_in(srst), .pwr_rst_in(prst), .cfg_wr_en_in(wr),
    .cfg_rd_en_in(rd), .cfg_addr_in(addr), .cfg_be_in(be), .cfg_wdata_in(wd), .cfg_rdata_out(rdat),
    .cfg_rd_valid_out(rdv), .global_first_error_in(gfirst), .dram_err_in(ev[7]), .sysbus_err_in(ev[6]),
    .hub_link_b_err_in(ev[5]), .hub_link_c_err_in(ev[4]), .hub_link_d_err_in(ev[3]),
    .hub_a_target_abort_in(ev[2]), .hub_a_data_par_in(ev[1]), .hub_a_addr_par_in(ev[0]),
    .system_error_enable_in(sen), .control_interrupt_out(cirq), .management_interrupt_out(mirq),
    .system_error_out(serr));
  initial begin
    forever #2.5 clk = ~clk;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task wreg(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
    @(posedge clk);
    {wr, addr, be, wd} <= {1'b1, a, b, d};
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    {rd, addr} <= {1'b1, a};
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk({31'h0, rdv}, 32'h1);
    chk(rdat, exp);
  endtask
  // Event pulse; system error may land in either of the two following cycles
  task pulse(input logic [7:0] v);
    @(posedge clk);
    ev <= v;
    @(posedge clk);
    ev <= 8'h00;
    #1;
    seen = serr;
    @(posedge clk);
    #1;
    seen |= serr;
  endtask
  task end_sim;
    $display("comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    {srst, prst} <= 2'b00;
    rchk(8'h44, 32'h0);
    rchk(8'h50, 32'h0);
    wreg(8'h58, 4'h5, 32'h00C000B1);
    rchk(8'h58, 32'h00400011);
    pulse(8'h02);
    chk({31'h0, cirq}, 32'h1);
    pulse(8'h05);
    chk({31'h0, mirq}, 32'h1);
    rchk(8'h50, 32'h00410010);
    wreg(8'h50, 4'hF, 32'h0);
    rchk(8'h50, 32'h00410010);
    wreg(8'h50, 4'h5, 32'h00010010);
    @(posedge clk);
    #1;
    chk({31'h0, cirq}, 32'h0);
    rchk(8'h50, 32'h00400000);
    $display("hub link a test finished");
    @(posedge clk);
    gfirst <= 32'h00020000;
    pulse(8'hF8);
    chk({31'h0, seen}, 32'h1);
    rchk(8'h44, 32'h0000001C);
    wreg(8'h44, 4'hF, 32'h0000001C);
    @(posedge clk);
    gfirst <= 32'h00000004;
    pulse(8'hE2);
    rchk(8'h44, 32'h00070000);
    @(posedge clk);
    sen <= 1'b0;
    pulse(8'h10);
    chk({31'h0, seen}, 32'h0);
    rchk(8'h44, 32'h00070008);
    $display("global test finished");
    @(posedge clk);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    rchk(8'h44, 32'h00070008);
    rchk(8'h58, 32'h0);
    rchk(8'h60, 32'h0);
    $display("reset test finished");
    end_sim;
  end
  // Tests need about 60 cycles; this 4000-cycle limit leaves ample margin
  initial begin
    #20000;
    error_cnt++;
    end_sim;
  end
endmodule
`default_nettype wire
